// ---- include/dwt_pkg.sv ----
// Package with register map, field layout, reset values and timing of the converter control.
package dwt_pkg;
  // Register byte offsets.
  localparam logic [7:0] CTRL_A_OFS = 8'h00;
  localparam logic [7:0] CTRL_B_OFS = 8'h04;
  localparam logic [7:0] DATA_A_OFS = 8'h08;
  localparam logic [7:0] DATA_B_OFS = 8'h0C;
  localparam logic [7:0] CLK_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;
  // Channel control field positions.
  localparam int EN_BIT = 0;
  localparam int MODE_BIT = 1;
  localparam int DMA_BIT = 2;
  localparam int TRIG_EN_BIT = 3;
  localparam int SRC_LSB = 4;
  localparam int EDGE_LSB = 6;
  localparam int WAVE_LSB = 8;
  localparam int RANGE_LSB = 10;
  localparam int PEAK_LSB = 12;
  localparam int STEP_LSB = 16;
  localparam int UPONLY_BIT = 18;
  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [9:0] DATA_RST = 10'h000;
  localparam logic [1:0] CLK_RST = 2'h0;
  // Wave selections.
  localparam logic [1:0] WAVE_NONE = 2'h0;
  localparam logic [1:0] WAVE_TRI = 2'h1;
  localparam logic [1:0] WAVE_SINE = 2'h2;
  localparam logic [1:0] WAVE_NOISE = 2'h3;
  localparam logic [1:0] WAVE_DIFF = 2'h3;
  // Edge types.
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Timing.
  localparam int CLK_HZ = 50_000_000;
  localparam int RATE_MAX_HZ = 500_000;
  localparam int DIV_FAST = CLK_HZ / RATE_MAX_HZ;
  localparam int TRI_DELAY = 3;
  localparam int SINE_LEN = 16;
  localparam logic [9:0] LFSR_SEED = 10'h001;
endpackage

// ---- rtl/dwt_ctrl.sv ----
// Two-channel converter control with waveform generation, triggers and DMA requests.
// Function
// - Asynchronous mode accepts new channel data at any time.
// - Channel A wave select 10 enables sine generation.
// - Sine period starts at zero phase, one sample per conversion tick, sixteen samples per period.
// - Sine amplitude follows channel A range field.
// - Sine on channel A; differential mode gives inverted sine on B.
// - Triangle counter advances three cycles after each channel A trigger.
// - Triangle rises only while below selected peak.
// - Increment size follows the step select field.
// - Up-down mode ramps down to channel A base value, then rises.
// - Up-only mode returns to base immediately at peak.
// - A pseudo-noise mode drives a random sequence.
// - DMA enabled channel requests data after each conversion tick.
// - Both channels raise independent DMA requests.
// - Each channel picks one of four trigger sources.
// - A selected timer match counts as a trigger.
// - Pin triggers detect rising, falling or both edges.
// - Without events the channel holds its previous value.
// - Each trigger loads the data register into the converter.
// - Channel B wave select 11 selects differential output.
// - Clock field selects 62.5, 125, 250 or 500 kHz.
// - Synchronous mode refreshes data at the conversion pace.
// - A channel is powered only when its enable bit is set.
`timescale 1ns/1ps
`default_nettype none
module dwt_ctrl
  import dwt_pkg::*;
(
  input wire logic aclk, // System clock, 50 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic timer_two_match, // Timer match pulse.
  input wire logic timer_three_match, // Timer match pulse.
  input wire logic gpio_trig_a, // Trigger pin, asynchronous.
  input wire logic gpio_trig_b, // Trigger pin, asynchronous.
  input wire logic [1:0] dma_ack, // DMA acknowledge per channel.
  output logic [1:0] dma_req, // DMA request per channel.
  output logic [9:0] conv_a, // Converter code for channel A.
  output logic [9:0] conv_b, // Converter code for channel B.
  output logic [1:0] conv_range, // Output range for both channels.
  output logic [1:0] chan_power // Channel power enables.
);
  logic [31:0] ctrl_q [2];
  logic [9:0] chan_a_value_reg;
  logic [9:0] data_b_q;
  logic [1:0] clk_ctrl_q;
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] gpio_s1_q, gpio_s2_q;
  logic [3:0] src_vec;
  logic [1:0] evt;
  logic [6:0] div_q;
  logic tick;
  logic [3:0] phase_q;
  logic [2:0] tri_dly_q;
  logic [9:0] tri_q;
  logic tri_down_q;
  logic [9:0] lfsr_q;
  logic [9:0] sine_code;
  logic [9:0] peak;
  logic [9:0] step;
  logic [1:0] wave_a;
  logic diff_mode;
  logic do_write;
  logic [31:0] wmerge;
  logic [31:0] rd_val;

  // AXI write: address and data in either order, response after both.
  assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign s_axi_bresp = 2'h0;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  always_comb
  begin
    unique case (awaddr_q)
      CTRL_A_OFS: wmerge = merge(ctrl_q[0], wdata_q, wstrb_q);
      CTRL_B_OFS: wmerge = merge(ctrl_q[1], wdata_q, wstrb_q);
      DATA_A_OFS: wmerge = merge({22'h0, chan_a_value_reg}, wdata_q, wstrb_q);
      DATA_B_OFS: wmerge = merge({22'h0, data_b_q}, wdata_q, wstrb_q);
      CLK_OFS: wmerge = merge({30'h0, clk_ctrl_q}, wdata_q, wstrb_q);
      default: wmerge = 32'h0000_0000;
    endcase
  end

  // Data registers take a write at any moment; only the AXI write path writes here.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q[0] <= CTRL_RST;
      ctrl_q[1] <= CTRL_RST;
      chan_a_value_reg <= DATA_RST;
      data_b_q <= DATA_RST;
      clk_ctrl_q <= CLK_RST;
    end
    else if (do_write)
    begin
      unique case (awaddr_q)
        CTRL_A_OFS: ctrl_q[0] <= wmerge;
        CTRL_B_OFS: ctrl_q[1] <= wmerge;
        DATA_A_OFS: chan_a_value_reg <= wmerge[9:0];
        DATA_B_OFS: data_b_q <= wmerge[9:0];
        CLK_OFS: clk_ctrl_q <= wmerge[1:0];
        default: ;
      endcase
    end
  end

  // AXI read: one cycle to answer, unmapped reads return zero with OKAY.
  always_comb
  begin
    unique case (s_axi_araddr)
      CTRL_A_OFS: rd_val = ctrl_q[0];
      CTRL_B_OFS: rd_val = ctrl_q[1];
      DATA_A_OFS: rd_val = {22'h0, chan_a_value_reg};
      DATA_B_OFS: rd_val = {22'h0, data_b_q};
      CLK_OFS: rd_val = {30'h0, clk_ctrl_q};
      STAT_OFS: rd_val = {8'h0, phase_q, tri_down_q, dma_req, conv_b[6:0], conv_a};
      default: rd_val = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;

  // Conversion tick: divide by 100, 200, 400 or 800.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_q <= 7'h00;
    else if (div_q == 7'(DIV_FAST - 1))
      div_q <= 7'h00;
    else
      div_q <= div_q + 7'h01;
  end
  logic [2:0] pre_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_q <= 3'h0;
    else if (div_q == 7'(DIV_FAST - 1))
      pre_q <= pre_q + 3'h1;
  end
  always_comb
  begin
    unique case (clk_ctrl_q)
      2'h3: tick = (div_q == 7'(DIV_FAST - 1));
      2'h2: tick = (div_q == 7'(DIV_FAST - 1)) && pre_q[0];
      2'h1: tick = (div_q == 7'(DIV_FAST - 1)) && (pre_q[1:0] == 2'h3);
      default: tick = (div_q == 7'(DIV_FAST - 1)) && (pre_q == 3'h7);
    endcase
  end

  // Trigger pins pass two flip-flops before the edge logic.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gpio_s1_q <= 2'h0;
      gpio_s2_q <= 2'h0;
    end
    else
    begin
      gpio_s1_q <= {gpio_trig_b, gpio_trig_a};
      gpio_s2_q <= gpio_s1_q;
    end
  end
  assign src_vec = {gpio_s2_q, timer_three_match, timer_two_match};

  for (genvar c = 0; c < 2; c++)
  begin : g_trig
    dwt_edge_sel u_sel (
      .aclk(aclk),
      .aresetn(aresetn),
      .src_vec(src_vec),
      .src_sel(ctrl_q[c][SRC_LSB +: 2]),
      .edge_type(ctrl_q[c][EDGE_LSB +: 2]),
      .event_p(evt[c])
    );
  end

  assign wave_a = ctrl_q[0][WAVE_LSB +: 2];
  assign diff_mode = (ctrl_q[1][WAVE_LSB +: 2] == WAVE_DIFF);
  assign peak = {ctrl_q[0][PEAK_LSB +: 4], 6'h3F};
  assign step = 10'h001 << ctrl_q[0][STEP_LSB +: 2];

  // Full-period sine table of sixteen phases, scaled by range.
  function automatic logic [9:0] sine_lut(input logic [3:0] ph);
    logic [9:0] v;
    unique case (ph)
      4'h0, 4'h8: v = 10'h200;
      4'h1, 4'h7: v = 10'h2C4;
      4'h2, 4'h6: v = 10'h36A;
      4'h3, 4'h5: v = 10'h3D8;
      4'h4: v = 10'h3FF;
      4'h9, 4'hF: v = 10'h13C;
      4'hA, 4'hE: v = 10'h096;
      4'hB, 4'hD: v = 10'h028;
      default: v = 10'h000;
    endcase
    return v;
  endfunction
  logic [9:0] sraw;
  assign sraw = sine_lut(phase_q);
  always_comb
  begin
    unique case (ctrl_q[0][RANGE_LSB +: 2])
      2'h0: sine_code = 10'h200 + (10'(sraw >> 2) - 10'h080);
      2'h1, 2'h2: sine_code = 10'h200 + (10'(sraw >> 1) - 10'h100);
      default: sine_code = sraw;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || wave_a != WAVE_SINE)
      phase_q <= 4'h0;
    else if (tick)
      phase_q <= phase_q + 4'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lfsr_q <= LFSR_SEED;
    else if (tick)
      lfsr_q <= {lfsr_q[8:0], lfsr_q[9] ^ lfsr_q[6]};
  end

  // Triangle advance fires three cycles after channel A trigger.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tri_dly_q <= 3'h0;
    else
      tri_dly_q <= {tri_dly_q[1:0], evt[0]};
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || wave_a != WAVE_TRI)
    begin
      tri_q <= chan_a_value_reg;
      tri_down_q <= 1'b0;
    end
    else if (tri_dly_q[2])
    begin
      if (!tri_down_q)
      begin
        if (tri_q < peak && peak - tri_q > step)
          tri_q <= tri_q + step;
        else if (ctrl_q[0][UPONLY_BIT] && tri_q >= peak)
          tri_q <= chan_a_value_reg;
        else
        begin
          tri_q <= peak;
          tri_down_q <= !ctrl_q[0][UPONLY_BIT];
        end
      end
      else if (tri_q > chan_a_value_reg && tri_q - chan_a_value_reg > step)
        tri_q <= tri_q - step;
      else
      begin
        tri_q <= chan_a_value_reg;
        tri_down_q <= 1'b0;
      end
    end
  end

  // Converter loads: trigger mode on events, otherwise on ticks or immediately.
  logic [1:0] load;
  for (genvar c = 0; c < 2; c++)
  begin : g_load
    always_comb
    begin
      if (ctrl_q[c][TRIG_EN_BIT])
        load[c] = evt[c];
      else if (ctrl_q[c][MODE_BIT])
        load[c] = tick;
      else
        load[c] = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      conv_a <= DATA_RST;
    else if (ctrl_q[0][EN_BIT])
    begin
      unique case (wave_a)
        WAVE_SINE: conv_a <= sine_code;
        WAVE_TRI: conv_a <= tri_q;
        WAVE_NOISE: conv_a <= lfsr_q;
        default: if (load[0]) conv_a <= chan_a_value_reg;
      endcase
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      conv_b <= DATA_RST;
    else if (ctrl_q[1][EN_BIT])
    begin
      if (diff_mode && ctrl_q[0][EN_BIT] && wave_a == WAVE_SINE)
        conv_b <= ~sine_code;
      else if (load[1])
        conv_b <= data_b_q;
    end
  end

  // DMA request raised after each conversion tick, cleared by acknowledge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dma_req <= 2'h0;
    else
      for (int c = 0; c < 2; c++)
        if (!ctrl_q[c][DMA_BIT])
          dma_req[c] <= 1'b0;
        else if (tick)
          dma_req[c] <= 1'b1;
        else if (dma_ack[c])
          dma_req[c] <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      conv_range <= 2'h0;
      chan_power <= 2'h0;
    end
    else
    begin
      conv_range <= ctrl_q[0][RANGE_LSB +: 2];
      chan_power <= {ctrl_q[1][EN_BIT], ctrl_q[0][EN_BIT]};
    end
  end
endmodule
`default_nettype wire

// ---- rtl/dwt_edge_sel.sv ----
// Per-channel trigger source selection and edge detection.
`timescale 1ns/1ps
`default_nettype none
module dwt_edge_sel
  import dwt_pkg::*;
(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [3:0] src_vec, // Timer matches and synchronised pins.
  input wire logic [1:0] src_sel, // Chosen source.
  input wire logic [1:0] edge_type, // Pin edge selection.
  output logic event_p // One-cycle trigger pulse.
);
  logic pin_prev_q;
  logic pin_now;
  assign pin_now = src_vec[src_sel];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_prev_q <= 1'b0;
    else
      pin_prev_q <= pin_now;
  end
  always_comb
  begin
    if (src_sel[1] == 1'b0)
      event_p = pin_now;
    else
      event_p = (edge_type[0] & pin_now & ~pin_prev_q) |
                (edge_type[1] & ~pin_now & pin_prev_q);
  end
endmodule
`default_nettype wire

// ---- test/dwt_ctrl_properties.sv ----
// Checker of bus handshakes, DMA requests and reset state of the converter control.
`timescale 1ns/1ps
`default_nettype none
module dwt_ctrl_properties
  import dwt_pkg::*;
(
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic [1:0] s_axi_bresp, // Write response.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic [1:0] s_axi_rresp, // Read response.
  input wire logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [1:0] dma_ack, // DMA acknowledge.
  input wire logic [1:0] dma_req, // DMA request.
  input wire logic [9:0] conv_a, // Channel A code.
  input wire logic [1:0] chan_power // Channel power.
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  a_resp_okay: assert property ((s_axi_bresp | s_axi_rresp) == 2'h0)
    else $error("response code not okay");
  a_ack_clears: assert property (
    (dma_req & dma_ack) != 2'h0 |=> (dma_req & $past(dma_req & dma_ack)) == 2'h0)
    else $error("request kept after acknowledge");
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> conv_a == 10'h000 && dma_req == 2'h0 && chan_power == 2'h0)
    else $error("outputs active in reset");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_ack: cover property (dma_req[0] && dma_ack[0]);
  c_both_req: cover property (dma_req == 2'h3);
endmodule
bind dwt_ctrl dwt_ctrl_properties u_props (.*);
`default_nettype wire

// ---- test/dwt_ctrl_tb.sv ----
// Self-checking bench for the converter control with a DMA partner.
`timescale 1ns/1ps
`default_nettype none
module dwt_ctrl_tb
  import dwt_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, slow, cv_go, dn;
  logic timer_two_match, timer_three_match, gpio_trig_a, gpio_trig_b;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, exp_rd [$];
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, dma_ack, dma_req, conv_range, chan_power, rg;
  logic [9:0] conv_a, conv_b, d, old, v;
  logic [15:0] ack_a, ack_b;
  logic [13:0] exp_cv [$];
  int num_errors, n_tests, seed, n;
  dwt_ctrl dut (.*);
  dwt_dma_model u_dma (.*);
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task fail(input string nm);
    num_errors++;
    $display("ERROR %s expected answer seen timeout", nm);
    test_done;
  endtask
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready) chk("read data", exp_rd.pop_front(), s_axi_rdata);
    if (cv_go) chk("outputs", 32'(exp_cv.pop_front()), {chan_power, conv_range, conv_a});
  end
  task wr(input logic [7:0] a, input logic [31:0] dt);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (k == 50) fail("write");
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    int k;
    @(posedge aclk);
    exp_rd.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (k == 50) fail("read");
  endtask
  task cv(input logic [13:0] e);
    @(posedge aclk);
    exp_cv.push_back(e);
    cv_go <= 1'b1;
    @(posedge aclk);
    cv_go <= 1'b0;
  endtask
  task hit(input int s, input logic lv);
    @(posedge aclk);
    case (s)
      0: timer_two_match <= lv;
      1: timer_three_match <= lv;
      2: gpio_trig_a <= lv;
      default: gpio_trig_b <= lv;
    endcase
    @(posedge aclk);
    timer_two_match <= 1'b0;
    timer_three_match <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  task rst;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task per(output int m);
    int k, r;
    logic p;
    p = 1'b1;
    r = 0;
    m = 0;
    for (k = 0; k < 4000; k++)
    begin
      @(posedge aclk);
      if (dma_req[0] && !p) r++;
      if (r == 3) break;
      if (r == 2) m++;
      p = dma_req[0];
    end
    if (k == 4000) fail("dma request");
  endtask
  initial
  begin
    repeat (100000) @(posedge aclk);
    fail("run");
  end
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow, cv_go} = '0;
    {timer_two_match, timer_three_match, gpio_trig_a, gpio_trig_b} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    num_errors = 0;
    n_tests = 0;
    seed = 32'hd3de;
    rst;
    cv(14'h0);
    rd(CTRL_A_OFS, CTRL_RST);
    rd(DATA_A_OFS, 32'(DATA_RST));
    rd(CLK_OFS, 32'(CLK_RST));
    rd(8'h18, 32'h0);
    $display("test reset done");
    rg = 2'($random(seed));
    d = 10'($random(seed));
    wr(CTRL_A_OFS, 32'h1 | 32'(rg) << RANGE_LSB);
    wr(DATA_A_OFS, {22'h0, d});
    repeat (3) @(posedge aclk);
    cv({2'h1, rg, d});
    rd(DATA_A_OFS, {22'h0, d});
    old = d;
    $display("test async done");
    for (int s = 0; s < 4; s++)
      for (int e = 1; e < 4; e++)
      begin
        d = 10'($random(seed));
        wr(CTRL_A_OFS, 32'h9 | s << SRC_LSB | e << EDGE_LSB | 32'(rg) << RANGE_LSB);
        wr(DATA_A_OFS, {22'h0, d});
        repeat (4) @(posedge aclk);
        cv({2'h1, rg, old});
        hit(s, 1'b1);
        if (s < 2 || e % 2 == 1) old = d;
        cv({2'h1, rg, old});
        hit(s, 1'b0);
        if (s > 1 && e > 1) old = d;
        cv({2'h1, rg, old});
      end
    $display("test trigger done");
    for (int u = 0; u < 2; u++)
    begin
      rst;
      v = 10'h0;
      dn = 1'b0;
      wr(CTRL_A_OFS, 32'h9 | u << UPONLY_BIT | 32'(WAVE_TRI) << WAVE_LSB);
      for (int k = 0; k < 140; k++)
      begin
        hit(0, 1'b1);
        if (v == 10'h3F && !dn) {dn, v} = u ? 11'h0 : {1'b1, 10'h3E};
        else if (v == 10'h0 && dn) {dn, v} = 11'h1;
        else v = dn ? v - 10'h1 : v + 10'h1;
        cv({4'h4, v});
      end
    end
    $display("test triangle done");
    wr(CTRL_A_OFS, 32'h5);
    wr(CTRL_B_OFS, 32'h5);
    for (int c = 0; c < 4; c++)
    begin
      slow <= c[0];
      wr(CLK_OFS, 32'(c));
      per(n);
      chk("dma period", 32'(800 >> c), 32'(n));
    end
    chk("dma pair", 32'h1, 32'(ack_a + 16'h1 - ack_b <= 16'h2));
    $display("test dma done");
    wr(CTRL_A_OFS, 32'h1 | 32'(WAVE_SINE) << WAVE_LSB | 32'h3 << RANGE_LSB);
    wr(CTRL_B_OFS, 32'h1 | 32'(WAVE_DIFF) << WAVE_LSB);
    repeat (5) @(posedge aclk);
    v = conv_a;
    chk("sine inverted", {22'h0, ~conv_a}, {22'h0, conv_b});
    repeat (DIV_FAST) @(posedge aclk);
    chk("sine step", 32'h1, 32'(conv_a != v));
    repeat (SINE_LEN * DIV_FAST - DIV_FAST) @(posedge aclk);
    chk("sine period", {22'h0, v}, {22'h0, conv_a});
    wr(CTRL_A_OFS, 32'h1 | 32'(WAVE_NOISE) << WAVE_LSB);
    repeat (2) @(posedge aclk);
    v = conv_a;
    repeat (DIV_FAST) @(posedge aclk);
    chk("noise step", 32'h1, 32'(conv_a != v));
    d = 10'($random(seed));
    wr(DATA_B_OFS, {22'h0, d});
    repeat (3) @(posedge aclk);
    chk("chan b", {22'h0, d}, {22'h0, conv_b});
    $display("test wave done");
    test_done;
  end
endmodule
`default_nettype wire

// ---- test/dwt_dma_model.sv ----
// Partner model of a DMA controller that acknowledges each channel request.
`timescale 1ns/1ps
`default_nettype none
module dwt_dma_model
  import dwt_pkg::*;
(
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic [1:0] dma_req, // Requests from the block.
  input wire logic slow, // Long answer delay when high.
  output logic [1:0] dma_ack, // One-cycle acknowledge.
  output logic [15:0] ack_a, // Acknowledges on channel A.
  output logic [15:0] ack_b // Acknowledges on channel B.
);
  logic [3:0] wait_q [2];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dma_ack <= 2'h0;
      ack_a <= 16'h0;
      ack_b <= 16'h0;
      wait_q[0] <= 4'h0;
      wait_q[1] <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        dma_ack[i] <= 1'b0;
        if (dma_req[i] && !dma_ack[i])
          wait_q[i] <= wait_q[i] + 4'h1;
        if (dma_req[i] && !dma_ack[i] && wait_q[i] == (slow ? 4'h9 : 4'h1))
        begin
          dma_ack[i] <= 1'b1;
          wait_q[i] <= 4'h0;
        end
      end
      ack_a <= ack_a + 16'(dma_ack[0]);
      ack_b <= ack_b + 16'(dma_ack[1]);
    end
  end
endmodule
`default_nettype wire
